// file: logic/brk_pkg.sv
package brk_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] OFS_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_ADDR_HIGH = 3'h1;
  localparam logic [2:0] OFS_ADDR_LOW = 3'h2;
  localparam logic [2:0] OFS_LOW_POWER_STATUS = 3'h3;
  localparam logic [2:0] OFS_FLAG_CLEAR_CONTROL = 3'h4;
  localparam logic [2:0] OFS_IRQ_STATUS = 3'h5;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h6;
  // Field positions
  localparam int BIT_BREAK_ENABLE = 7;
  localparam int BIT_BREAK_ACTIVE = 6;
  localparam int BIT_EXITED_LOW_POWER = 1;
  localparam int BIT_CLEAR_FLAG_ENABLE = 7;
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_SOFT = 1;
  localparam int IRQ_WAKE = 2;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;
  // Vector addresses handed to the core with each request
  localparam logic [15:0] VEC_NORMAL = 16'hFFFC;
  localparam logic [15:0] VEC_MONITOR = 16'hFEFC;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PEND = 2'b01,
    ST_BREAK = 2'b10
  } brk_state_type;
endpackage

// file: logic/addr_match.sv
`timescale 1ns/100ps
module addr_match
  import brk_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Compare
  input wire logic enable,
  input wire logic [WIDTH-1:0] bus_addr,
  input wire logic [WIDTH-1:0] breakpoint_request_addr,
  output logic hit_q
);
  wire logic equal;
  if (WIDTH < 1) begin : width_check
    $error("addr_match width must be positive");
  end
  // Full-width compare, runs in every mode including wait
  assign equal = enable && (bus_addr == breakpoint_request_addr);
  always_ff @(posedge clock) begin
    if (rst) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= equal;
    end
  end
  hit_gate_a: assert property (@(posedge clock) disable iff (rst)
    !enable |=> !hit_q) else $error("hit without enable");
endmodule

// file: logic/break_unit.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module break_unit
  import brk_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata_q,
  // CPU and system integration side
  input wire logic [15:0] cpu_addr,
  input wire logic instr_last,
  input wire logic return_from_interrupt,
  input wire logic monitor_mode,
  input wire logic in_stop,
  input wire logic in_wait,
  input wire logic reset_pin_high_voltage,
  output logic breakpoint_request_q,
  output logic [15:0] break_vector_q,
  output logic break_state_q,
  output logic timer_freeze_q,
  output logic watchdog_disable_q,
  output logic flag_clear_allowed_q,
  output logic wake_q,
  // Interrupt
  output logic irq_q
);
  logic break_enable_bit_q;
  logic break_active_bit_q;
  logic [7:0] addr_high_q;
  logic [7:0] addr_low_q;
  logic break_exited_low_power_flag_q;
  logic clear_flag_enable_bit_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;
  logic hv_meta_q;
  logic hv_sync_q;
  logic monitor_meta_q;
  logic monitor_sync_q;
  brk_state_type state_q;
  brk_state_type state_d;
  wire logic hit;
  wire logic wr_scr = reg_write && (reg_addr == OFS_STATUS_CONTROL);
  wire logic wr_high = reg_write && (reg_addr == OFS_ADDR_HIGH);
  wire logic wr_low = reg_write && (reg_addr == OFS_ADDR_LOW);
  wire logic wr_bsr = reg_write && (reg_addr == OFS_LOW_POWER_STATUS);
  wire logic wr_break_flag_clear_control = reg_write && (reg_addr == OFS_FLAG_CLEAR_CONTROL);
  wire logic wr_istat = reg_write && (reg_addr == OFS_IRQ_STATUS);
  wire logic wr_imask = reg_write && (reg_addr == OFS_IRQ_MASK);
  wire logic soft_break = wr_scr && reg_wdata[BIT_BREAK_ACTIVE];
  wire logic match_event = hit && break_enable_bit_q && (state_q == ST_IDLE);
  wire logic trigger = match_event || (soft_break && state_q == ST_IDLE);
  wire logic low_power = in_stop || in_wait;
  wire logic fire_now = ((state_q == ST_PEND) || trigger) && instr_last;
  wire logic [2:0] irq_events = {trigger && low_power, soft_break, match_event};
  wire logic [7:0] rd_mux =
    (reg_addr == OFS_STATUS_CONTROL) ?
      {break_enable_bit_q, break_active_bit_q, 6'h00} :
    (reg_addr == OFS_ADDR_HIGH) ? addr_high_q :
    (reg_addr == OFS_ADDR_LOW) ? addr_low_q :
    (reg_addr == OFS_LOW_POWER_STATUS) ? {6'h00, break_exited_low_power_flag_q, 1'b0} :
    (reg_addr == OFS_FLAG_CLEAR_CONTROL) ? {clear_flag_enable_bit_q, 7'h00} :
    (reg_addr == OFS_IRQ_STATUS) ? {5'h00, irq_status_q} :
    (reg_addr == OFS_IRQ_MASK) ? {5'h00, irq_mask_q} : 8'h00;

  addr_match #(.WIDTH(16)) u_match (
    .clock(clock),
    .rst(rst),
    .enable(break_enable_bit_q),
    .bus_addr(cpu_addr),
    .breakpoint_request_addr({addr_high_q, addr_low_q}),
    .hit_q(hit)
  );

  // Break sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (trigger) begin
          state_d = instr_last ? ST_BREAK : ST_PEND;
        end
      end
      ST_PEND: begin
        if (instr_last) begin
          state_d = ST_BREAK;
        end
      end
      ST_BREAK: begin
        if (return_from_interrupt) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= (state_q == ST_PEND && !instr_last) ? ST_PEND : state_d;
    end
  end

  // Two-stage synchronisers for pin-level inputs
  always_ff @(posedge clock) begin
    if (rst) begin
      hv_meta_q <= 1'b0;
      hv_sync_q <= 1'b0;
    end else begin
      hv_meta_q <= reset_pin_high_voltage;
      hv_sync_q <= hv_meta_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      monitor_meta_q <= 1'b0;
      monitor_sync_q <= 1'b0;
    end else begin
      monitor_meta_q <= monitor_mode;
      monitor_sync_q <= monitor_meta_q;
    end
  end

  // Registers
  always_ff @(posedge clock) begin
    if (rst) begin
      break_enable_bit_q <= 1'b0;
    end else if (wr_scr) begin
      break_enable_bit_q <= reg_wdata[BIT_BREAK_ENABLE];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      addr_high_q <= RST_BYTE;
    end else if (wr_high) begin
      addr_high_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      addr_low_q <= RST_BYTE;
    end else if (wr_low) begin
      addr_low_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      clear_flag_enable_bit_q <= 1'b0;
    end else if (wr_break_flag_clear_control) begin
      clear_flag_enable_bit_q <= reg_wdata[BIT_CLEAR_FLAG_ENABLE];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_mask_q <= RST_IRQ;
    end else if (wr_imask) begin
      irq_mask_q <= reg_wdata[2:0];
    end
  end

  // Active bit: set wins over software clear
  always_ff @(posedge clock) begin
    if (rst) begin
      break_active_bit_q <= 1'b0;
    end else if (match_event || soft_break) begin
      break_active_bit_q <= 1'b1;
    end else if (wr_scr && !reg_wdata[BIT_BREAK_ACTIVE]) begin
      break_active_bit_q <= 1'b0;
    end
  end

  // Low-power exit flag: set wins over clear
  always_ff @(posedge clock) begin
    if (rst) begin
      break_exited_low_power_flag_q <= 1'b0;
    end else if (trigger && low_power) begin
      break_exited_low_power_flag_q <= 1'b1;
    end else if (wr_bsr && !reg_wdata[BIT_EXITED_LOW_POWER]) begin
      break_exited_low_power_flag_q <= 1'b0;
    end
  end

  // Interrupt status, write one to clear, events win
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_status_q <= RST_IRQ;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_events | (irq_status_q & ~(wr_istat ? reg_wdata[2:0] : 3'h0));
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // Outputs toward core, timer, watchdog and peer modules
  always_ff @(posedge clock) begin
    if (rst) begin
      breakpoint_request_q <= 1'b0;
    end else begin
      breakpoint_request_q <= fire_now;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      break_vector_q <= VEC_NORMAL;
    end else begin
      break_vector_q <= monitor_sync_q ? VEC_MONITOR : VEC_NORMAL;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      break_state_q <= 1'b0;
    end else begin
      break_state_q <= (state_d == ST_BREAK);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      timer_freeze_q <= 1'b0;
    end else begin
      timer_freeze_q <= (state_d == ST_BREAK);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      watchdog_disable_q <= 1'b0;
    end else begin
      watchdog_disable_q <= (state_d == ST_BREAK) && hv_sync_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flag_clear_allowed_q <= 1'b1;
    end else begin
      flag_clear_allowed_q <= (state_d != ST_BREAK) || clear_flag_enable_bit_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= trigger && in_stop;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata_q <= RST_BYTE;
    end else begin
      reg_rdata_q <= reg_read ? rd_mux : RST_BYTE;
    end
  end

  freeze_tracks_a: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_BREAK) |-> timer_freeze_q) else $error("timer not frozen");
  clear_gate_a: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_BREAK && !clear_flag_enable_bit_q && $past(state_q) == ST_BREAK
     && $stable(clear_flag_enable_bit_q)) |-> !flag_clear_allowed_q)
    else $error("clear allowed in break");
  soft_break_a: assert property (@(posedge clock) disable iff (rst)
    soft_break |=> break_active_bit_q) else $error("soft break lost");
  match_disabled_a: assert property (@(posedge clock) disable iff (rst)
    (!break_enable_bit_q && !soft_break && !break_active_bit_q) |=> !break_active_bit_q)
    else $error("active set while disabled");
  pending_fire_a: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_PEND && instr_last) |=> breakpoint_request_q)
    else $error("pending break not issued");
  rti_ends_a: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_BREAK && return_from_interrupt) |=> state_q == ST_IDLE)
    else $error("break not ended");
  lp_flag_a: assert property (@(posedge clock) disable iff (rst)
    (trigger && low_power) |=> break_exited_low_power_flag_q)
    else $error("low-power flag missed");
  wdog_off_a: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_BREAK && $past(state_q) == ST_BREAK && hv_sync_q && $past(hv_sync_q))
    |-> watchdog_disable_q) else $error("watchdog on in break");
  req_pulse_a: assert property (@(posedge clock) disable iff (rst)
    breakpoint_request_q |=> !breakpoint_request_q)
    else $error("request longer than one cycle");
  req_enters_a: assert property (@(posedge clock) disable iff (rst)
    breakpoint_request_q |-> state_q == ST_BREAK)
    else $error("request outside break entry");
  match_pend_a: assert property (@(posedge clock) disable iff (rst)
    (match_event && !instr_last) |=> state_q == ST_PEND)
    else $error("mid-instruction match not deferred");
  soft_now_a: assert property (@(posedge clock) disable iff (rst)
    (soft_break && state_q == ST_IDLE && instr_last) |=> breakpoint_request_q)
    else $error("soft break not issued");
  active_clear_a: assert property (@(posedge clock) disable iff (rst)
    (wr_scr && !reg_wdata[BIT_BREAK_ACTIVE] && !match_event) |=> !break_active_bit_q)
    else $error("active bit not cleared");
  enable_load_a: assert property (@(posedge clock) disable iff (rst)
    wr_scr |=> break_enable_bit_q == $past(reg_wdata[BIT_BREAK_ENABLE]))
    else $error("enable bit not written");
  addr_load_a: assert property (@(posedge clock) disable iff (rst)
    wr_high |=> addr_high_q == $past(reg_wdata))
    else $error("address high not written");
  vector_mode_a: assert property (@(posedge clock) disable iff (rst)
    monitor_sync_q |=> break_vector_q == VEC_MONITOR)
    else $error("monitor vector missing");
  vector_normal_a: assert property (@(posedge clock) disable iff (rst)
    !monitor_sync_q |=> break_vector_q == VEC_NORMAL)
    else $error("normal vector missing");
  wake_stop_a: assert property (@(posedge clock) disable iff (rst)
    (trigger && in_stop) |=> wake_q)
    else $error("stop wake missed");
  lp_clear_a: assert property (@(posedge clock) disable iff (rst)
    (wr_bsr && !reg_wdata[BIT_EXITED_LOW_POWER] && !(trigger && low_power))
    |=> !break_exited_low_power_flag_q) else $error("low-power flag not cleared");
  rdata_idle_a: assert property (@(posedge clock) disable iff (rst)
    !reg_read |=> reg_rdata_q == RST_BYTE)
    else $error("read data outside read cycle");
  irq_level_a: assert property (@(posedge clock) disable iff (rst)
    (|(irq_status_q & irq_mask_q)) |=> irq_q)
    else $error("interrupt not raised");
endmodule

// file: test/cpu_model.sv
`timescale 1ns/100ps
module cpu_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bench control
  input wire logic load,
  input wire logic [15:0] load_pc,
  // Break unit side
  input wire logic breakpoint_request_q,
  input wire logic [15:0] break_vector_q,
  output logic [15:0] cpu_addr,
  output logic instr_last,
  output logic return_from_interrupt,
  output logic [15:0] vector_seen_q
);
  logic [15:0] pc_q;
  logic [3:0] svc_q;
  assign cpu_addr = pc_q;
  // Four-cycle instructions
  assign instr_last = pc_q[1:0] == 2'h3;
  assign return_from_interrupt = svc_q == 4'h1;
  always_ff @(posedge clock) begin
    if (rst) begin
      pc_q <= 16'h0000;
      svc_q <= 4'h0;
      vector_seen_q <= 16'h0000;
    end else begin
      if (load) begin
        pc_q <= load_pc;
      end else if (svc_q == 4'h0) begin
        pc_q <= pc_q + 16'h0001;
      end
      if (breakpoint_request_q) begin
        svc_q <= 4'hF;
        vector_seen_q <= break_vector_q;
      end else if (svc_q != 4'h0) begin
        svc_q <= svc_q - 4'h1;
      end
    end
  end
endmodule

// file: test/break_unit_test.sv
`timescale 1ns/100ps
module break_unit_test;
  import brk_pkg::*;
  logic clock = 0, rst = 1, reg_write = 0, reg_read = 0, load = 0;
  logic monitor_mode = 0, in_stop = 0, in_wait = 0, reset_pin_high_voltage = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata_q;
  logic [15:0] load_pc = 16'h0000, cpu_addr, break_vector_q, vector_seen_q;
  logic instr_last, return_from_interrupt, breakpoint_request_q, break_state_q;
  logic timer_freeze_q, watchdog_disable_q, flag_clear_allowed_q, wake_q, irq_q;
  int failures = 0, num_checks = 0, cycles = 0, req_n = 0, wake_n = 0;
  always #10 clock = ~clock;
  break_unit u_break_unit (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_q(reg_rdata_q), .cpu_addr(cpu_addr), .instr_last(instr_last),
    .return_from_interrupt(return_from_interrupt), .monitor_mode(monitor_mode),
    .in_stop(in_stop), .in_wait(in_wait), .reset_pin_high_voltage(reset_pin_high_voltage),
    .breakpoint_request_q(breakpoint_request_q), .break_vector_q(break_vector_q),
    .break_state_q(break_state_q), .timer_freeze_q(timer_freeze_q),
    .watchdog_disable_q(watchdog_disable_q), .flag_clear_allowed_q(flag_clear_allowed_q),
    .wake_q(wake_q), .irq_q(irq_q));
  cpu_model u_cpu_model (.clock(clock), .rst(rst), .load(load), .load_pc(load_pc),
    .breakpoint_request_q(breakpoint_request_q), .break_vector_q(break_vector_q),
    .cpu_addr(cpu_addr), .instr_last(instr_last),
    .return_from_interrupt(return_from_interrupt), .vector_seen_q(vector_seen_q));
  always @(posedge clock) begin
    cycles++;
    if (breakpoint_request_q === 1'b1) req_n++;
    if (wake_q === 1'b1) wake_n++;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask
  task automatic start_at(input logic [15:0] pc);
    @(posedge clock);
    load <= 1'b1;
    load_pc <= pc;
    @(posedge clock);
    load <= 1'b0;
  endtask
  task automatic wait_end();
    for (int i = 0; i < 40 && break_state_q !== 1'b0; i++) tick(1);
    chk(break_state_q, 0);
  endtask
  task automatic t_reset();
    chk(break_vector_q, VEC_NORMAL);
    chk(flag_clear_allowed_q, 1);
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
  endtask
  task automatic t_match();
    int n;
    n = req_n;
    @(posedge clock);
    in_wait <= 1'b1;
    wr(OFS_ADDR_HIGH, 8'h12);
    wr(OFS_ADDR_LOW, 8'h34);
    wr(OFS_FLAG_CLEAR_CONTROL, 8'h80);
    wr(OFS_STATUS_CONTROL, 8'h80);
    start_at(16'h1230);
    tick(14);
    chk(req_n, n + 1);
    chk({break_state_q, timer_freeze_q, watchdog_disable_q}, 3'b110);
    chk(vector_seen_q, VEC_NORMAL);
    chk(flag_clear_allowed_q, 1);
    rd(OFS_STATUS_CONTROL, 8'hC0);
    rd(OFS_LOW_POWER_STATUS, 8'h02);
    wr(OFS_STATUS_CONTROL, 8'h00);
    rd(OFS_STATUS_CONTROL, 8'h00);
    wr(OFS_LOW_POWER_STATUS, 8'h00);
    rd(OFS_LOW_POWER_STATUS, 8'h00);
    wait_end();
    @(posedge clock);
    in_wait <= 1'b0;
  endtask
  task automatic t_disabled();
    int n;
    n = req_n;
    start_at(16'h1230);
    tick(20);
    chk(req_n, n);
    rd(OFS_STATUS_CONTROL, 8'h00);
  endtask
  task automatic t_soft();
    int n;
    n = req_n;
    @(posedge clock);
    monitor_mode <= 1'b1;
    reset_pin_high_voltage <= 1'b1;
    in_stop <= 1'b1;
    wr(OFS_FLAG_CLEAR_CONTROL, 8'h00);
    wr(OFS_IRQ_MASK, 8'h07);
    tick(4);
    wr(OFS_STATUS_CONTROL, 8'h40);
    tick(5);
    chk(req_n, n + 1);
    chk(wake_n, 1);
    chk(vector_seen_q, VEC_MONITOR);
    chk(watchdog_disable_q, 1);
    chk(flag_clear_allowed_q, 0);
    chk(irq_q, 1);
    wr(OFS_FLAG_CLEAR_CONTROL, 8'h80);
    tick(2);
    chk(flag_clear_allowed_q, 1);
    rd(OFS_LOW_POWER_STATUS, 8'h02);
    wr(OFS_STATUS_CONTROL, 8'h00);
    rd(OFS_STATUS_CONTROL, 8'h00);
    chk(break_state_q, 1);
    rd(OFS_IRQ_STATUS, 8'h07);
    wr(OFS_IRQ_MASK, 8'h00);
    tick(2);
    chk(irq_q, 0);
    wr(OFS_IRQ_MASK, 8'h07);
    wr(OFS_IRQ_STATUS, 8'h07);
    tick(2);
    chk(irq_q, 0);
    wr(OFS_LOW_POWER_STATUS, 8'h00);
    wait_end();
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_match();
    t_disabled();
    t_soft();
    test_done();
  end
endmodule
